// ---- sawc_pkg.sv ----
// Constants for the converter sequencer with window comparator
package sawc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the AXI4-Lite slave
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_ONE = 8'h00; // Converter control one
    localparam logic [7:0] OFS_CTRL_TWO = 8'h04; // Converter control two
    localparam logic [7:0] OFS_RES_HIGH = 8'h08; // Result high byte
    localparam logic [7:0] OFS_RES_LOW = 8'h0C; // Result low byte
    localparam logic [7:0] OFS_WIN_UPPER = 8'h10; // Window upper limit
    localparam logic [7:0] OFS_WIN_LOWER = 8'h14; // Window lower limit
    localparam logic [7:0] OFS_SHARED_SEL = 8'h18; // Shared select register
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C; // Sticky event status
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20; // Interrupt mask

    // ------------------------------------------------------------
    // Decoded register indices
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL_ONE = 4'h0;
    localparam logic [3:0] IDX_CTRL_TWO = 4'h1;
    localparam logic [3:0] IDX_RES_HIGH = 4'h2;
    localparam logic [3:0] IDX_RES_LOW = 4'h3;
    localparam logic [3:0] IDX_WIN_UPPER = 4'h4;
    localparam logic [3:0] IDX_WIN_LOWER = 4'h5;
    localparam logic [3:0] IDX_SHARED_SEL = 4'h6;
    localparam logic [3:0] IDX_IRQ_STATUS = 4'h7;
    localparam logic [3:0] IDX_IRQ_MASK = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C1_START_BUSY = 7; // Start / busy
    localparam int C1_CONTINUOUS = 5; // Continuous mode
    localparam int C1_EXT_START = 4; // External start enable
    localparam int C1_QUALIFIER = 3; // Interrupt qualifier
    localparam int C1_MATCH = 2; // Window match flag (read only)
    localparam int C1_POWER = 1; // Converter power enable
    localparam int C1_POLARITY = 0; // Window polarity
    localparam int C2_FORMAT = 7; // Output format
    localparam int C2_CHAN_LSB = 4; // Channel field bits 6..4
    localparam int C2_PRESC_LSB = 0; // Prescaler field bits 3..0
    localparam int SEL_REF = 7; // Reference select in shared register
    localparam int ST_CONV_DONE = 0; // Conversion complete event

    // ------------------------------------------------------------
    // Reset values, timing and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00; // All registers reset to zero
    localparam logic [3:0] CONV_LAST_TICK = 4'hF; // Sixteen converter clocks
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- sawc_adc_ctrl.sv ----
// Converter sequencer, result formatting, window compare and AXI4-Lite slave
//
// Overview of operation
// - Converter powered down while power bit zero.
// - Reference select: 0 internal, 1 external pair.
// - Channel field bits 6..4 selects input.
// - Software start bit begins conversion, one-shot, while external start is off.
// - External start: active-low pin level starts.
// - Continuous mode restarts after each completion.
// - Conversion lasts exactly sixteen converter clocks.
// - Converter clock period is machine period times N+1.
// - Prescaler field bits 3..0, resets zero.
// - Low result holds eight least significant bits.
// - Format zero: high byte holds bits 9..2.
// - Format one: high byte bits 9..8, rest zero.
// - Match equals polarity xor two limit compares.
// - Match flag at bit 2, hardware updated.
// - Qualifier zero: interrupt after every conversion.
// - Qualifier one: interrupt only on match.
module sawc_adc_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic extStartN,
    input wire logic [9:0] sarResult,
    output logic powerUp,
    output logic refExternal,
    output logic [2:0] channelSel,
    output logic converting,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic awready; // Write address ready
        logic wready; // Write data ready
        logic bvalid; // Write response valid
        logic [1:0] bresp; // Write response code
        logic awHeld; // Write address captured
        logic [7:0] awAddr; // Captured write address
        logic wHeld; // Write data captured
        logic [7:0] wData; // Captured low byte
        logic wLane; // Byte lane zero enabled
        logic arready; // Read address ready
        logic rvalid; // Read data valid
        logic [1:0] rresp; // Read response code
        logic [7:0] rdata; // Read byte
        logic pwr; // Converter power enable
        logic cont; // Continuous mode
        logic external_start_enable; // External start enable
        logic interrupt_qualifier_bit; // Interrupt qualifier
        logic window_polarity_bit; // Window polarity
        logic match; // Window match flag
        logic busy; // Conversion in progress
        logic fmt; // Output format
        logic [2:0] chan; // Channel select
        logic [3:0] presc; // Prescaler setting
        logic refSel; // Reference select
        logic [7:0] resHi; // Result high byte
        logic [7:0] resLo; // Result low byte
        logic [7:0] window_upper_limit; // Window upper limit
        logic [7:0] window_lower_limit; // Window lower limit
        logic status; // Sticky conversion event
        logic mask; // Interrupt mask
        logic irq; // Interrupt output
        logic [3:0] prescRun; // Prescaler frozen for this conversion
        logic [3:0] divCnt; // Machine cycles within a converter clock
        logic [3:0] tickCnt; // Converter clocks done
        logic syncA; // Start pin first stage
        logic syncB; // Start pin second stage
    } sawc_state_s;

    sawc_state_s s_q; // Registered state
    sawc_state_s s_d; // Next state
    logic convDone; // Last machine cycle of a conversion
    logic startReq; // A start is requested now
    logic swStart; // Software wrote one to start
    logic [3:0] wIdx; // Decoded write register
    logic [3:0] rIdx; // Decoded read register
    logic [7:0] msb8; // Top eight result bits
    logic newMatch; // Window compare outcome

    // ------------------------------------------------------------
    // Address decode, shared by read and write paths
    // ------------------------------------------------------------
    function automatic logic [3:0] regIndex(input logic [7:0] a);
        logic [3:0] r;
        r = sawc_pkg::IDX_NONE;
        if (a == sawc_pkg::OFS_CTRL_ONE) begin
            r = sawc_pkg::IDX_CTRL_ONE;
        end else if (a == sawc_pkg::OFS_CTRL_TWO) begin
            r = sawc_pkg::IDX_CTRL_TWO;
        end else if (a == sawc_pkg::OFS_RES_HIGH) begin
            r = sawc_pkg::IDX_RES_HIGH;
        end else if (a == sawc_pkg::OFS_RES_LOW) begin
            r = sawc_pkg::IDX_RES_LOW;
        end else if (a == sawc_pkg::OFS_WIN_UPPER) begin
            r = sawc_pkg::IDX_WIN_UPPER;
        end else if (a == sawc_pkg::OFS_WIN_LOWER) begin
            r = sawc_pkg::IDX_WIN_LOWER;
        end else if (a == sawc_pkg::OFS_SHARED_SEL) begin
            r = sawc_pkg::IDX_SHARED_SEL;
        end else if (a == sawc_pkg::OFS_IRQ_STATUS) begin
            r = sawc_pkg::IDX_IRQ_STATUS;
        end else if (a == sawc_pkg::OFS_IRQ_MASK) begin
            r = sawc_pkg::IDX_IRQ_MASK;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Everything is gated by ce, so a low enable freezes the whole block
    always_comb begin
        s_d = s_q;
        convDone = 1'b0;
        swStart = 1'b0;
        startReq = 1'b0;
        wIdx = regIndex(s_q.awAddr);
        rIdx = regIndex(araddr);
        msb8 = sarResult[9:2];
        // Lower bounds are inclusive on both limits
        newMatch = s_q.window_polarity_bit ^ (s_q.window_upper_limit <= msb8)
            ^ (s_q.window_lower_limit <= msb8);
        if (ce) begin
            // Start pin synchroniser; only syncB is used by logic
            s_d.syncA = extStartN;
            s_d.syncB = s_q.syncA;

            // Write channels are taken in either order
            if (s_q.awready && awvalid) begin
                s_d.awHeld = 1'b1;
                s_d.awAddr = awaddr;
            end
            if (s_q.wready && wvalid) begin
                s_d.wHeld = 1'b1;
                s_d.wData = wdata[7:0];
                s_d.wLane = wstrb[0];
            end
            if (s_q.bvalid && bready) begin
                s_d.bvalid = 1'b0;
            end
            // Perform the write once both halves are in and no answer waits
            if (s_q.awHeld && s_q.wHeld && !s_q.bvalid) begin
                s_d.awHeld = 1'b0;
                s_d.wHeld = 1'b0;
                s_d.bvalid = 1'b1;
                s_d.bresp = sawc_pkg::RESP_OKAY;
                if (wIdx == sawc_pkg::IDX_NONE) begin
                    s_d.bresp = sawc_pkg::RESP_SLVERR;
                end else if (s_q.wLane) begin
                    case (wIdx)
                        sawc_pkg::IDX_CTRL_ONE: begin
                            // Match and busy are hardware owned
                            s_d.cont = s_q.wData[sawc_pkg::C1_CONTINUOUS];
                            s_d.external_start_enable = s_q.wData[sawc_pkg::C1_EXT_START];
                            s_d.interrupt_qualifier_bit = s_q.wData[sawc_pkg::C1_QUALIFIER];
                            s_d.pwr = s_q.wData[sawc_pkg::C1_POWER];
                            s_d.window_polarity_bit = s_q.wData[sawc_pkg::C1_POLARITY];
                            swStart = s_q.wData[sawc_pkg::C1_START_BUSY]
                                && !s_d.external_start_enable && s_d.pwr;
                        end
                        sawc_pkg::IDX_CTRL_TWO: begin
                            s_d.fmt = s_q.wData[sawc_pkg::C2_FORMAT];
                            s_d.chan = s_q.wData[
                                sawc_pkg::C2_CHAN_LSB +: 3];
                            s_d.presc = s_q.wData[
                                sawc_pkg::C2_PRESC_LSB +: 4];
                        end
                        sawc_pkg::IDX_WIN_UPPER: begin
                            s_d.window_upper_limit = s_q.wData;
                        end
                        sawc_pkg::IDX_WIN_LOWER: begin
                            s_d.window_lower_limit = s_q.wData;
                        end
                        sawc_pkg::IDX_SHARED_SEL: begin
                            s_d.refSel = s_q.wData[sawc_pkg::SEL_REF];
                        end
                        sawc_pkg::IDX_IRQ_MASK: begin
                            s_d.mask = s_q.wData[sawc_pkg::ST_CONV_DONE];
                        end
                        default: begin
                            // Read-only registers ignore writes
                        end
                    endcase
                end
            end
            s_d.awready = !s_d.awHeld;
            s_d.wready = !s_d.wHeld;

            // Read channel: one answer outstanding at a time
            if (s_q.rvalid && rready) begin
                s_d.rvalid = 1'b0;
            end
            if (s_q.arready && arvalid) begin
                s_d.rvalid = 1'b1;
                s_d.rresp = sawc_pkg::RESP_OKAY;
                s_d.rdata = sawc_pkg::RST_BYTE;
                case (rIdx)
                    sawc_pkg::IDX_CTRL_ONE: begin
                        s_d.rdata = {s_q.busy, 1'b0, s_q.cont, s_q.external_start_enable,
                            s_q.interrupt_qualifier_bit, s_q.match, s_q.pwr, s_q.window_polarity_bit};
                    end
                    sawc_pkg::IDX_CTRL_TWO: begin
                        s_d.rdata = {s_q.fmt, s_q.chan, s_q.presc};
                    end
                    sawc_pkg::IDX_RES_HIGH: begin
                        s_d.rdata = s_q.resHi;
                    end
                    sawc_pkg::IDX_RES_LOW: begin
                        s_d.rdata = s_q.resLo;
                    end
                    sawc_pkg::IDX_WIN_UPPER: begin
                        s_d.rdata = s_q.window_upper_limit;
                    end
                    sawc_pkg::IDX_WIN_LOWER: begin
                        s_d.rdata = s_q.window_lower_limit;
                    end
                    sawc_pkg::IDX_SHARED_SEL: begin
                        s_d.rdata = {s_q.refSel, 7'h00};
                    end
                    sawc_pkg::IDX_IRQ_STATUS: begin
                        // Read clears; a same-cycle event sets it again below
                        s_d.rdata = {7'h00, s_q.status};
                        s_d.status = 1'b0;
                    end
                    sawc_pkg::IDX_IRQ_MASK: begin
                        s_d.rdata = {7'h00, s_q.mask};
                    end
                    default: begin
                        s_d.rresp = sawc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            s_d.arready = !s_d.rvalid;

            // Conversion sequencer
            // The pin is a level: held low it keeps requesting
            startReq = swStart || (s_q.external_start_enable && !s_q.syncB);
            if (!s_d.pwr) begin
                // Power-down aborts a conversion in flight
                s_d.busy = 1'b0;
                s_d.divCnt = 4'h0;
                s_d.tickCnt = 4'h0;
            end else if (s_q.busy) begin
                // One converter clock is prescaler+1 machine cycles
                if (s_q.divCnt == s_q.prescRun) begin
                    s_d.divCnt = 4'h0;
                    s_d.tickCnt = s_q.tickCnt + 4'h1;
                    convDone = (s_q.tickCnt
                        == sawc_pkg::CONV_LAST_TICK);
                end else begin
                    s_d.divCnt = s_q.divCnt + 4'h1;
                end
                if (convDone) begin
                    // Results and flag land in one edge
                    s_d.resLo = sarResult[7:0];
                    s_d.resHi = s_q.fmt ? {6'h00, sarResult[9:8]}
                        : sarResult[9:2];
                    s_d.match = newMatch;
                    if (!s_q.interrupt_qualifier_bit || newMatch) begin
                        s_d.status = 1'b1;
                    end
                    // Continuous mode chains straight into the next one
                    s_d.busy = s_q.cont || startReq;
                    s_d.tickCnt = 4'h0;
                    s_d.prescRun = s_q.presc;
                end
            end else if (startReq) begin
                // Prescaler latched so a rewrite cannot stretch this one
                s_d.busy = 1'b1;
                s_d.divCnt = 4'h0;
                s_d.tickCnt = 4'h0;
                s_d.prescRun = s_q.presc;
            end
            s_d.irq = s_d.status && s_d.mask;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = {24'h00_0000, s_q.rdata};
    assign powerUp = s_q.pwr;
    assign refExternal = s_q.refSel;
    assign channelSel = s_q.chan;
    assign converting = s_q.busy;
    assign irq = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Enabled cycles since the current conversion began
    logic [8:0] convCycles;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            convCycles <= 9'h000;
        end else if (ce) begin
            convCycles <= (convDone || !s_q.busy) ? 9'h000
                : convCycles + 9'h001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_power_off_abort: assert property (
        ce && !s_d.pwr |=> !converting && !s_q.busy)
        else $error("converter busy while powered down");
    a_ref_follow: assert property (
        ce && s_q.awHeld && s_q.wHeld && !s_q.bvalid && s_q.wLane
        && wIdx == sawc_pkg::IDX_SHARED_SEL
        |=> refExternal == $past(s_q.wData[7]))
        else $error("reference select not taken from write");
    a_chan_follow: assert property (
        ce && s_q.awHeld && s_q.wHeld && !s_q.bvalid && s_q.wLane
        && wIdx == sawc_pkg::IDX_CTRL_TWO
        |=> channelSel == $past(s_q.wData[6:4]))
        else $error("channel select not taken from write");
    a_sw_start: assert property (
        ce && swStart && !s_q.busy |=> converting)
        else $error("software start did not begin conversion");
    a_pin_start: assert property (
        ce && s_q.external_start_enable && s_d.pwr && !s_q.syncB && !s_q.busy |=> converting)
        else $error("external pin start ignored");
    a_conv_length: assert property (
        convDone |-> convCycles
        == ({5'h00, s_q.prescRun} + 9'h001) * 9'h010 - 9'h001)
        else $error("conversion length wrong");
    a_result_low: assert property (
        convDone && s_d.pwr |=> s_q.resLo == $past(sarResult[7:0])
        && s_q.match == $past(newMatch))
        else $error("low result or match not updated at end");
    a_result_high: assert property (
        convDone && s_d.pwr |=> s_q.resHi == ($past(s_q.fmt)
        ? {6'h00, $past(sarResult[9:8])} : $past(sarResult[9:2])))
        else $error("high result format wrong");
    // With upper above lower the flag is polarity xor inside the window
    a_window_eq: assert property (
        convDone && s_d.pwr && s_q.window_upper_limit > s_q.window_lower_limit
        |=> s_q.match == ($past(s_q.window_polarity_bit) ^ ($past(sarResult[9:2])
        >= $past(s_q.window_lower_limit) && $past(sarResult[9:2]) < $past(s_q.window_upper_limit))))
        else $error("window compare equation wrong");
    a_irq_qualify: assert property (
        convDone && s_d.pwr |=> s_q.status
        == ($past(s_q.status) && !$past(s_q.arready && arvalid
        && rIdx == sawc_pkg::IDX_IRQ_STATUS)
        || !$past(s_q.interrupt_qualifier_bit) || $past(newMatch)))
        else $error("event status not qualified correctly");
    a_busy_clear: assert property (
        convDone && s_d.pwr |=> converting == $past(s_q.cont || startReq))
        else $error("busy not cleared or restarted at end");

    c_one_shot: cover property (convDone && !s_q.cont);
    c_continuous: cover property (convDone ##1 converting [*3]);
    c_qualified_drop: cover property (convDone && s_q.interrupt_qualifier_bit && !newMatch);
    c_irq_rise: cover property ($rose(irq));

endmodule

// ---- sawc_start_source.sv ----
// External start source and analog core stand-in facing the sequencer
module sawc_start_source (
    input wire logic clk,
    input wire logic go,
    input wire logic [9:0] value,
    output logic extStartN,
    output logic [9:0] sarResult
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Start pin
    // ------------------------------------------------------------
    int cnt = 0; // Cycles left with the pin pulled low
    // A request holds the pin low four cycles, long enough for the
    // two-flop synchroniser, short enough to ask for one conversion
    always @(posedge clk) begin
        if (go) begin
            cnt <= 4;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // Pin idles high through its pull-up; low level requests
    assign extStartN = (cnt == 0);
    // Core result held steady, as sample-and-hold would
    assign sarResult = value;
endmodule

// ---- tb.sv ----
// Self-checking bench for the converter sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, go, ce;
    logic awready, wready, bvalid, arready, rvalid;
    logic extStartN, powerUp, refExternal, converting, irq;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, br, rr;
    logic [9:0] sarResult, value;
    logic [2:0] channelSel;
    int n_errors = 0;
    int n_checks = 0;
    int n;
    // ------------------------------------------------------------
    // Instances; all strobes on
    // ------------------------------------------------------------
    sawc_adc_ctrl uut (.clk(clk), .resetn(resetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .extStartN(extStartN), .sarResult(sarResult), .powerUp(powerUp),
        .refExternal(refExternal), .channelSel(channelSel),
        .converting(converting), .irq(irq));
    sawc_start_source src (.clk(clk), .go(go), .value(value),
        .extStartN(extStartN), .sarResult(sarResult));
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // AXI4-Lite write; each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0000_00, v};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        fork
            begin do @(posedge clk); while (awready !== 1'b1); awvalid <= 0; end
            begin do @(posedge clk); while (wready !== 1'b1); wvalid <= 0; end
        join
        while (bvalid !== 1'b1) @(posedge clk);
        br = bresp;
        bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata[7:0];
        rr = rresp;
        rready <= 0;
    endtask
    // Counts cycles until the busy output drops, bounded
    task automatic run();
        n = 0;
        do begin @(posedge clk); n++; end while (converting === 1'b1 && n < 2000);
    endtask
    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, go} = '0;
        ce = 1;
        awaddr = 0;
        araddr = 0;
        wdata = 0;
        value = 10'h2B5;
        resetn = 0;
        repeat (8) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        rd(sawc_pkg::OFS_CTRL_ONE); chk(d, 8'h00);
        rd(sawc_pkg::OFS_CTRL_TWO); chk(d, 8'h00);
        chk({powerUp, refExternal}, 8'h00);
        wr(sawc_pkg::OFS_SHARED_SEL, 8'h80); chk(refExternal, 8'h01);
        // No prescaler reaches the 1 us converter period at this bench
        // clock; the short setting keeps the runs brief
        wr(sawc_pkg::OFS_CTRL_TWO, 8'h51); chk(channelSel, 8'h05);
        wr(sawc_pkg::OFS_WIN_UPPER, 8'hC0);
        wr(sawc_pkg::OFS_WIN_LOWER, 8'h80);
        wr(sawc_pkg::OFS_IRQ_MASK, 8'h01);
        // Software one-shot, prescaler 1: sixteen periods of two cycles
        wr(sawc_pkg::OFS_CTRL_ONE, 8'h82);
        run();
        chk(n >= 30 && n <= 34, 8'h01);
        repeat (4) @(posedge clk);
        chk(converting, 8'h00);
        rd(sawc_pkg::OFS_RES_LOW); chk(d, 8'hB5);
        rd(sawc_pkg::OFS_RES_HIGH); chk(d, 8'hAD);
        chk(irq, 8'h01);
        rd(sawc_pkg::OFS_CTRL_ONE); chk(d, 8'h06);
        rd(sawc_pkg::OFS_IRQ_STATUS); chk(d, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 8'h00);
        // Right-justified format, qualified interrupt, no match
        wr(sawc_pkg::OFS_WIN_UPPER, 8'h90);
        wr(sawc_pkg::OFS_CTRL_TWO, 8'hD1);
        wr(sawc_pkg::OFS_CTRL_ONE, 8'h8A);
        // Enable low for ten cycles must stretch the conversion by ten
        ce <= 0;
        repeat (10) @(posedge clk);
        ce <= 1;
        run();
        chk(8'(n), 8'h20);
        rd(sawc_pkg::OFS_RES_HIGH); chk(d, 8'h02);
        rd(sawc_pkg::OFS_CTRL_ONE); chk(d, 8'h0A);
        rd(sawc_pkg::OFS_IRQ_STATUS); chk(d, 8'h00);
        chk(irq, 8'h00);
        // Pin start with the interrupt masked, then unmasked
        wr(sawc_pkg::OFS_IRQ_MASK, 8'h00);
        // Inverted window polarity as well
        wr(sawc_pkg::OFS_CTRL_ONE, 8'h13);
        value <= 10'h3FF;
        @(posedge clk) go <= 1;
        @(posedge clk) go <= 0;
        repeat (6) @(posedge clk);
        chk(converting, 8'h01);
        run();
        rd(sawc_pkg::OFS_RES_LOW); chk(d, 8'hFF);
        rd(sawc_pkg::OFS_CTRL_ONE); chk(d, 8'h17);
        chk(irq, 8'h00);
        wr(sawc_pkg::OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(irq, 8'h01);
        rd(sawc_pkg::OFS_IRQ_STATUS); chk(d, 8'h01);
        // Continuous mode keeps converting; power-down aborts
        wr(sawc_pkg::OFS_CTRL_ONE, 8'hA2);
        repeat (80) @(posedge clk);
        chk(converting, 8'h01);
        wr(sawc_pkg::OFS_CTRL_ONE, 8'h00);
        repeat (2) @(posedge clk);
        chk({powerUp, converting}, 8'h00);
        // Unmapped place answers with an error response
        wr(8'h40, 8'h01); chk(br, 8'h02);
        rd(8'h40); chk(rr, 8'h02);
        results();
    end
endmodule
